// ===== hdl/dsol_defines.vh
// Constants for the distance switch output logic
`ifndef DSOL_DEFINES_VH
`define DSOL_DEFINES_VH

// Clock rate and timer resolution
`define DSOL_CLK_MHZ 250
`define DSOL_TICK_MS 5
`define DSOL_US_PER_MS 1000
`define DSOL_LEARN_NT_MS 1000

// Widths and counts
`define DSOL_DW 16
`define DSOL_NSW 2
`define DSOL_CFG_W 7

// Switch register page: byte address = page base + 0x20 * switch index + offset
`define DSOL_SW_PAGE 2'h0
`define DSOL_OFS_CFG 5'h00
`define DSOL_OFS_SETPT 5'h04
`define DSOL_OFS_HYST 5'h08
`define DSOL_OFS_WNEAR 5'h0C
`define DSOL_OFS_WFAR 5'h10
`define DSOL_OFS_ONDLY 5'h14
`define DSOL_OFS_OFFDLY 5'h18
`define DSOL_OFS_NTDLY 5'h1C

// Shared registers
`define DSOL_ADDR_NOSYNC 8'h40
`define DSOL_ADDR_SYNC 8'h44
`define DSOL_ADDR_STATUS 8'h48

// Configuration word fields
`define DSOL_CFG_MODE 0
`define DSOL_CFG_POL 1
`define DSOL_CFG_PWR 2
`define DSOL_CFG_NT 4:3
`define DSOL_CFG_NS 6:5
`define DSOL_SYNC_SLAVE 0

// Forced actions
`define DSOL_ACT_OFF 2'h0
`define DSOL_ACT_ON 2'h1
`define DSOL_ACT_HOLD 2'h2

// Reset values, distances in 0.01 inch
`define DSOL_CFG1_RST 7'h00
`define DSOL_CFG2_RST 7'h02
`define DSOL_SETPT_RST 16'h0BB8
`define DSOL_WIDTH_RST 16'h0019
`define DSOL_HYST_RST 16'h0019
`define DSOL_HYST_MAX 16'h56A1
`define DSOL_DLY_RST 16'h0000
`define DSOL_DIST_RST 16'h0000
`define DSOL_RANGE_MIN 16'h0064
`define DSOL_RANGE_MAX 16'h2EE0

// Pushbutton learn codes
`define DSOL_LRN_SP1 5'h07
`define DSOL_LRN_POL1 5'h08
`define DSOL_LRN_SP2 5'h09
`define DSOL_LRN_POL2 5'h0A
`define DSOL_LRN_NT1S 5'h14
`define DSOL_LRN_NT0 5'h15

`endif

// ===== hdl/dsol_tick.v
// Common 5 ms tick divider and shared no-sync watchdog
`timescale 1ns/100ps
`include "dsol_defines.vh"
module dsol_tick #(
  parameter TICK_CYCLES = 1250000,
  parameter CNT_W = 21,
  parameter DW = `DSOL_DW
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Sync watch
  input wire syncSlave,
  input wire syncSeen,
  input wire [DW-1:0] noSyncDly,
  // Results
  output reg tick_q,
  output reg noSync_q
);
  reg [CNT_W-1:0] div_q;
  reg [DW-1:0] missCnt_q;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      div_q <= {CNT_W{1'b0}};
      tick_q <= 1'b0;
    end else if (div_q == TICK_CYCLES[CNT_W-1:0] - 1'b1) begin
      div_q <= {CNT_W{1'b0}};
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // One delay for every output; counts whole ticks since last sync
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      missCnt_q <= {DW{1'b0}};
      noSync_q <= 1'b0;
    end else begin
      if (!syncSlave || syncSeen) begin
        missCnt_q <= {DW{1'b0}};
      end else if (tick_q && !(&missCnt_q)) begin
        missCnt_q <= missCnt_q + 1'b1;
      end
      noSync_q <= syncSlave && !syncSeen && (missCnt_q > noSyncDly);
    end
  end
endmodule

// ===== hdl/dsol_switch.v
// Decision logic of one switch output
`timescale 1ns/100ps
`include "dsol_defines.vh"
module dsol_switch #(
  parameter DW = `DSOL_DW
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  input wire tick,
  // Measurement
  input wire measDone,
  input wire measValid,
  input wire [DW-1:0] measDist,
  input wire noSync,
  // Configuration
  input wire [`DSOL_CFG_W-1:0] cfg,
  input wire [DW-1:0] setpt,
  input wire [DW-1:0] hyst,
  input wire [DW-1:0] wNear,
  input wire [DW-1:0] wFar,
  input wire [DW-1:0] onDly,
  input wire [DW-1:0] offDly,
  input wire [DW-1:0] ntDly,
  input wire [DW-1:0] rangeMin,
  input wire [DW-1:0] rangeMax,
  // State
  output reg swOn_q,
  output reg warn_q,
  output reg noTgt_q
);
  reg armed_q;
  reg condQ_q;
  reg absent_q;
  reg [DW-1:0] qualCnt_q;
  reg [DW-1:0] ntCnt_q;
  reg condNow;
  reg warnD;
  wire modeWin = cfg[`DSOL_CFG_MODE];
  wire pol = cfg[`DSOL_CFG_POL];
  wire [DW:0] spHi = {1'b0, setpt} + {1'b0, hyst};
  wire [DW:0] spLo = {1'b0, setpt} - {1'b0, hyst};
  wire [DW:0] winHi = {1'b0, wFar} + {1'b0, hyst};
  wire [DW:0] winLo = {1'b0, wNear} - {1'b0, hyst};
  wire inWin = (measDist >= wNear) && (measDist <= wFar);
  wire newMeas = measDone && measValid;
  wire ntFire = absent_q && (ntCnt_q >= ntDly);
  wire [DW-1:0] qualDly = condQ_q ? onDly : offDly;
  wire qualFire = (condQ_q != swOn_q) && (qualCnt_q >= qualDly);

  always @* begin
    if (modeWin) begin
      condNow = pol ? !inWin : inWin;
    end else if (!pol) begin
      // Closer: on at setpoint, off once at or beyond setpoint plus hysteresis
      condNow = swOn_q ? ({1'b0, measDist} < spHi) : (measDist <= setpt);
    end else begin
      condNow = swOn_q ? (spLo[DW] || ({1'b0, measDist} > spLo))
                       : (measDist >= setpt);
    end
  end

  always @* begin
    if (modeWin) begin
      warnD = (winHi > {1'b0, rangeMax}) || winLo[DW] || (winLo < {1'b0, rangeMin});
    end else if (!pol) begin
      warnD = spHi > {1'b0, rangeMax};
    end else begin
      warnD = spLo[DW] || (spLo < {1'b0, rangeMin});
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
      condQ_q <= 1'b0;
      absent_q <= 1'b0;
      qualCnt_q <= {DW{1'b0}};
      ntCnt_q <= {DW{1'b0}};
      swOn_q <= 1'b0;
      warn_q <= 1'b0;
      noTgt_q <= 1'b0;
    end else begin
      warn_q <= warnD;
      noTgt_q <= ntFire;
      if (measDone) begin
        armed_q <= 1'b1;
        absent_q <= !measValid;
      end
      if (newMeas) begin
        condQ_q <= condNow;
      end
      if (newMeas) begin
        ntCnt_q <= {DW{1'b0}};
      end else if (absent_q && tick && !(&ntCnt_q)) begin
        ntCnt_q <= ntCnt_q + 1'b1;
      end
      // Restart whenever the condition flips or matches the output
      if ((condQ_q == swOn_q) || (newMeas && (condNow != condQ_q))) begin
        qualCnt_q <= {DW{1'b0}};
      end else if (tick && !(&qualCnt_q)) begin
        qualCnt_q <= qualCnt_q + 1'b1;
      end
      if (!armed_q) begin
        swOn_q <= cfg[`DSOL_CFG_PWR];
      end else if (noSync) begin
        case (cfg[`DSOL_CFG_NS])
          `DSOL_ACT_ON: swOn_q <= 1'b1;
          `DSOL_ACT_OFF: swOn_q <= 1'b0;
          default: swOn_q <= swOn_q;
        endcase
      end else if (ntFire) begin
        case (cfg[`DSOL_CFG_NT])
          `DSOL_ACT_ON: swOn_q <= 1'b1;
          `DSOL_ACT_OFF: swOn_q <= 1'b0;
          default: swOn_q <= swOn_q;
        endcase
      end else if (!absent_q && qualFire) begin
        swOn_q <= condQ_q;
      end
    end
  end
endmodule

// ===== hdl/dsol_top.v
// Two-switch distance decision block with APB registers and learn codes
//
// What this block does
// - Setpoint mode: on at setpoint, off past hysteresis
// - Window mode: state from distance within window
// - Mode per switch, setpoint by default
// - Power-up state per switch, default off
// - Hold power-up state until first measurement
// - Learn 7/9 capture setpoint for switches
// - Setpoint polarity: on closer or farther
// - Window polarity: state inside window, opposite outside
// - Learn 8/10 invert polarity of switches
// - No target too long forces no-target action
// - No-target delay needs continuous absence
// - Learn 20 sets one second, 21 zero
// - Hysteresis up to 221.77 in, default 0.25
// - Warn when hysteresis leaves range window
// - On only after continuous on condition delay
// - Off only after continuous off condition delay
// - Sync slave without sync forces no-sync action
// - One no-sync delay shared by all outputs
// - Window far defaults setpoint plus 0.25 in
// - Window near defaults setpoint, learned 7/9
// - Learning near shifts far, width constant
// - No-sync delay needs continuous sync absence
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/100ps
`include "dsol_defines.vh"
module dsol_top #(
  parameter TICK_CYCLES = `DSOL_TICK_MS * `DSOL_US_PER_MS * `DSOL_CLK_MHZ,
  parameter DW = `DSOL_DW,
  parameter NSW = `DSOL_NSW,
  parameter [`DSOL_DW-1:0] RANGE_MIN = `DSOL_RANGE_MIN,
  parameter [`DSOL_DW-1:0] RANGE_MAX = `DSOL_RANGE_MAX
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Measurement engine
  input wire measDone,
  input wire measValid,
  input wire [DW-1:0] measDist,
  // Sync input pulse from master
  input wire syncSeen,
  // Pushbutton learn
  input wire learnStb,
  input wire [4:0] learnCode,
  // Switch outputs
  output wire switchOne,
  output wire switchTwo,
  output wire [NSW-1:0] cfgWarn
);
  localparam [DW-1:0] LEARN_NT_TICKS = `DSOL_LEARN_NT_MS / `DSOL_TICK_MS;
  localparam [DW-1:0] HYST_MAX = `DSOL_HYST_MAX;

  integer i;
  reg [`DSOL_CFG_W-1:0] cfg_q [0:NSW-1];
  reg [DW-1:0] setpt_q [0:NSW-1];
  reg [DW-1:0] hyst_q [0:NSW-1];
  reg [DW-1:0] wNear_q [0:NSW-1];
  reg [DW-1:0] wFar_q [0:NSW-1];
  reg [DW-1:0] onDly_q [0:NSW-1];
  reg [DW-1:0] offDly_q [0:NSW-1];
  reg [DW-1:0] ntDly_q [0:NSW-1];
  reg [DW-1:0] noSyncDly_q;
  reg syncSlave_q;
  reg [DW-1:0] lastDist_q;
  reg [31:0] rdData;
  reg rdErr;
  wire tick;
  wire noSync;
  wire [NSW-1:0] swOn;
  wire [NSW-1:0] swWarn;
  wire [NSW-1:0] swNoTgt;

  // Address decode
  wire inSw = paddr[7:6] == `DSOL_SW_PAGE;
  wire swIdx = paddr[5];
  wire [4:0] regOfs = paddr[4:0];
  wire setupPh = psel && !penable;
  wire wrEn = psel && penable && pready && pwrite;
  wire [DW-1:0] wrHalf = pwdata[DW-1:0];
  wire [DW-1:0] wrHyst = (wrHalf > HYST_MAX) ? HYST_MAX : wrHalf;

  always @* begin
    rdData = 32'h00000000;
    rdErr = 1'b0;
    if (inSw) begin
      case (regOfs)
        `DSOL_OFS_CFG: rdData = {25'h0000000, cfg_q[swIdx]};
        `DSOL_OFS_SETPT: rdData = {16'h0000, setpt_q[swIdx]};
        `DSOL_OFS_HYST: rdData = {16'h0000, hyst_q[swIdx]};
        `DSOL_OFS_WNEAR: rdData = {16'h0000, wNear_q[swIdx]};
        `DSOL_OFS_WFAR: rdData = {16'h0000, wFar_q[swIdx]};
        `DSOL_OFS_ONDLY: rdData = {16'h0000, onDly_q[swIdx]};
        `DSOL_OFS_OFFDLY: rdData = {16'h0000, offDly_q[swIdx]};
        `DSOL_OFS_NTDLY: rdData = {16'h0000, ntDly_q[swIdx]};
        default: rdErr = 1'b1;
      endcase
    end else begin
      case (paddr)
        `DSOL_ADDR_NOSYNC: rdData = {16'h0000, noSyncDly_q};
        `DSOL_ADDR_SYNC: rdData = {31'h00000000, syncSlave_q};
        `DSOL_ADDR_STATUS: rdData = {25'h0000000, noSync, swNoTgt, swWarn, swOn};
        default: rdErr = 1'b1;
      endcase
    end
  end

  // Answer is prepared in setup so access completes with no wait state
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setupPh;
      pslverr <= setupPh && rdErr;
      if (setupPh && !pwrite) begin
        prdata <= rdErr ? 32'h00000000 : rdData;
      end
    end
  end

  // Configuration storage; a bus write overrides a learn in the same cycle
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      for (i = 0; i < NSW; i = i + 1) begin
        setpt_q[i] <= `DSOL_SETPT_RST;
        hyst_q[i] <= `DSOL_HYST_RST;
        wNear_q[i] <= `DSOL_SETPT_RST;
        wFar_q[i] <= `DSOL_SETPT_RST + `DSOL_WIDTH_RST;
        onDly_q[i] <= `DSOL_DLY_RST;
        offDly_q[i] <= `DSOL_DLY_RST;
        ntDly_q[i] <= `DSOL_DLY_RST;
      end
      cfg_q[0] <= `DSOL_CFG1_RST;
      cfg_q[1] <= `DSOL_CFG2_RST;
      noSyncDly_q <= `DSOL_DLY_RST;
      syncSlave_q <= 1'b0;
      lastDist_q <= `DSOL_DIST_RST;
    end else begin
      if (measDone && measValid) begin
        lastDist_q <= measDist;
      end
      if (learnStb) begin
        case (learnCode)
          `DSOL_LRN_SP1: begin
            setpt_q[0] <= lastDist_q;
            wNear_q[0] <= lastDist_q;
            wFar_q[0] <= lastDist_q + (wFar_q[0] - wNear_q[0]);
          end
          `DSOL_LRN_SP2: begin
            setpt_q[1] <= lastDist_q;
            wNear_q[1] <= lastDist_q;
            wFar_q[1] <= lastDist_q + (wFar_q[1] - wNear_q[1]);
          end
          `DSOL_LRN_POL1: begin
            cfg_q[0][`DSOL_CFG_POL] <= !cfg_q[0][`DSOL_CFG_POL];
          end
          `DSOL_LRN_POL2: begin
            cfg_q[1][`DSOL_CFG_POL] <= !cfg_q[1][`DSOL_CFG_POL];
          end
          `DSOL_LRN_NT1S: begin
            for (i = 0; i < NSW; i = i + 1) begin
              ntDly_q[i] <= LEARN_NT_TICKS;
            end
          end
          `DSOL_LRN_NT0: begin
            for (i = 0; i < NSW; i = i + 1) begin
              ntDly_q[i] <= `DSOL_DLY_RST;
            end
          end
          default: begin
          end
        endcase
      end
      if (wrEn && inSw) begin
        case (regOfs)
          `DSOL_OFS_CFG: cfg_q[swIdx] <= pwdata[`DSOL_CFG_W-1:0];
          `DSOL_OFS_SETPT: setpt_q[swIdx] <= wrHalf;
          `DSOL_OFS_HYST: hyst_q[swIdx] <= wrHyst;
          `DSOL_OFS_WNEAR: wNear_q[swIdx] <= wrHalf;
          `DSOL_OFS_WFAR: wFar_q[swIdx] <= wrHalf;
          `DSOL_OFS_ONDLY: onDly_q[swIdx] <= wrHalf;
          `DSOL_OFS_OFFDLY: offDly_q[swIdx] <= wrHalf;
          `DSOL_OFS_NTDLY: ntDly_q[swIdx] <= wrHalf;
          default: begin
          end
        endcase
      end
      if (wrEn && !inSw) begin
        case (paddr)
          `DSOL_ADDR_NOSYNC: noSyncDly_q <= wrHalf;
          `DSOL_ADDR_SYNC: syncSlave_q <= pwdata[`DSOL_SYNC_SLAVE];
          default: begin
          end
        endcase
      end
    end
  end

  dsol_tick #(
    .TICK_CYCLES(TICK_CYCLES),
    .DW(DW)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .syncSlave(syncSlave_q),
    .syncSeen(syncSeen),
    .noSyncDly(noSyncDly_q),
    .tick_q(tick),
    .noSync_q(noSync)
  );

  genvar g;
  generate
    for (g = 0; g < NSW; g = g + 1) begin : gSw
      dsol_switch #(
        .DW(DW)
      ) u_sw (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick(tick),
        .measDone(measDone),
        .measValid(measValid),
        .measDist(measDist),
        .noSync(noSync),
        .cfg(cfg_q[g]),
        .setpt(setpt_q[g]),
        .hyst(hyst_q[g]),
        .wNear(wNear_q[g]),
        .wFar(wFar_q[g]),
        .onDly(onDly_q[g]),
        .offDly(offDly_q[g]),
        .ntDly(ntDly_q[g]),
        .rangeMin(RANGE_MIN),
        .rangeMax(RANGE_MAX),
        .swOn_q(swOn[g]),
        .warn_q(swWarn[g]),
        .noTgt_q(swNoTgt[g])
      );
    end
  endgenerate

  // Switch outputs are the flops inside each switch instance
  assign switchOne = swOn[0];
  assign switchTwo = swOn[1];
  assign cfgWarn = swWarn;
endmodule

// ===== dv/dsol_props.sv
// Port assertions for the distance switch block
`timescale 1ns/100ps
module dsol_props #(
  parameter NSW = 2
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Events and outputs
  input wire measDone,
  input wire learnStb,
  input wire switchOne,
  input wire switchTwo,
  input wire [NSW-1:0] cfgWarn
);
  reg armed_q;
  reg [1:0] pwr_q;
  wire wrAcc = psel && penable && pready && pwrite;
  wire rdAcc = psel && penable && pready && !pwrite;
  // Shadow of the power-up bits, so the hold can be judged without the bodies
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
      pwr_q <= 2'b00;
    end else begin
      if (measDone)
        armed_q <= 1'b1;
      if (wrAcc && paddr == 8'h00)
        pwr_q[0] <= pwdata[2];
      if (wrAcc && paddr == 8'h20)
        pwr_q[1] <= pwdata[2];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("answer outside access phase");
  a_ready_single: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  a_unmapped_error: assert property (psel && !penable && !pwrite && paddr > 8'h48
    |=> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
  a_mapped_clean: assert property (psel && !penable && paddr[1:0] == 2'h0 && paddr <= 8'h48
    |=> !pslverr) else $error("mapped access refused");
  a_status_view: assert property (rdAcc && paddr == 8'h48
    |-> prdata[3:0] == $past({cfgWarn, switchTwo, switchOne}))
    else $error("status differs from outputs");
  a_powerup_hold: assert property (!armed_q && !measDone && $stable(pwr_q)
    |-> {switchTwo, switchOne} == pwr_q) else $error("power-up state not held");
  a_warn_cause: assert property ($changed(cfgWarn) |-> $past(wrAcc, 1) || $past(wrAcc, 2)
    || $past(learnStb, 1) || $past(learnStb, 2) || $past(learnStb, 3))
    else $error("warning moved without a setting change");
endmodule

bind dsol_top dsol_props #(.NSW(NSW)) i_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .measDone(measDone), .learnStb(learnStb), .switchOne(switchOne),
  .switchTwo(switchTwo), .cfgWarn(cfgWarn)
);

// ===== dv/dsol_meas_model.sv
// Ranging engine stand-in: one strobe per requested measurement
`timescale 1ns/100ps
module dsol_meas_model (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Request from bench
  input wire go,
  input wire goValid,
  input wire [15:0] goDist,
  // Engine outputs
  output reg measDone_q,
  output reg measValid_q,
  output reg [15:0] measDist_q
);
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      measDone_q <= 1'b0;
      measValid_q <= 1'b0;
      measDist_q <= 16'h0000;
    end else if (go) begin
      measDone_q <= 1'b1;
      measValid_q <= goValid;
      measDist_q <= goDist;
    end else begin
      // Stale between strobes, so scramble rather than hold
      measDone_q <= 1'b0;
      measValid_q <= ~measValid_q;
      measDist_q <= ~measDist_q;
    end
  end
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the two-switch distance block
`timescale 1ns/100ps
module tb_top;
  reg clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg go = 1'b0, goValid = 1'b0, syncSeen = 1'b0, learnStb = 1'b0;
  reg [15:0] goDist = 16'h0000;
  reg [4:0] learnCode = 5'h00;
  wire [31:0] prdata;
  wire pready, pslverr, measDone, measValid, switchOne, switchTwo;
  wire [15:0] measDist;
  wire [1:0] cfgWarn;
  integer bad_count = 0, total_checks = 0, seed = 32'hf7c9, i;
  reg [15:0] d;
  logic [32:0] expQ[$];
  logic [7:0] ra[14] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20,
    8'h24, 8'h40, 8'h44, 8'h48, 8'h50};
  logic [32:0] re[14] = '{33'h0, 33'hBB8, 33'h19, 33'hBB8, 33'hBD1, 33'h0, 33'h0, 33'h0,
    33'h2, 33'hBB8, 33'h0, 33'h0, 33'h0, 33'h100000000};
  logic [15:0] hd[4] = '{16'h0BB8, 16'h0BC0, 16'h0B9F, 16'h0BD1};
  logic [3:0] he[4] = '{4'h3, 4'h3, 4'h1, 4'h2};
  dsol_top #(.TICK_CYCLES(20)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .measDone(measDone), .measValid(measValid),
    .measDist(measDist), .syncSeen(syncSeen), .learnStb(learnStb), .learnCode(learnCode),
    .switchOne(switchOne), .switchTwo(switchTwo), .cfgWarn(cfgWarn));
  dsol_meas_model i_eng (.clk_sys(clk_sys), .rst_n(rst_n), .go(go), .goValid(goValid),
    .goDist(goDist), .measDone_q(measDone), .measValid_q(measValid), .measDist_q(measDist));
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  task chk(input logic [32:0] got, input logic [32:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    xfer(1'b1, a, v);
  endtask
  task rd(input logic [7:0] a, input logic [32:0] e);
    expQ.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  // Waits past the two-cycle evaluation latency before anything is read
  task ms(input logic v, input logic [15:0] dd);
    @(posedge clk_sys);
    go <= 1'b1;
    goValid <= v;
    goDist <= dd;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (5) @(posedge clk_sys);
  endtask
  task lrn(input logic [4:0] c);
    @(posedge clk_sys);
    learnStb <= 1'b1;
    learnCode <= c;
    @(posedge clk_sys);
    learnStb <= 1'b0;
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    if (psel && penable && pready && !pwrite)
      chk({pslverr, prdata}, expQ.pop_front());
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count = bad_count + 1;
    conclude;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (i = 0; i < 14; i++) rd(ra[i], re[i]);
    wr(8'h00, 32'h4);
    rd(8'h48, 33'h1);
    ms(1'b1, 16'h1000);
    rd(8'h48, 33'h2);
    for (i = 0; i < 4; i++) begin
      ms(1'b1, hd[i]);
      rd(8'h48, {29'h0, he[i]});
    end
    lrn(5'h08);
    rd(8'h00, 33'h6);
    lrn(5'h0A);
    rd(8'h20, 33'h0);
    ms(1'b1, 16'h1000);
    rd(8'h48, 33'h1);
    d = {4'h0, 12'($random(seed))} + 16'h0400;
    ms(1'b1, d);
    ms(1'b0, 16'hFFFF);
    lrn(5'h07);
    lrn(5'h09);
    rd(8'h04, {17'h0, d});
    rd(8'h0C, {17'h0, d});
    rd(8'h10, {17'h0, d + 16'h0019});
    rd(8'h24, {17'h0, d});
    rd(8'h30, {17'h0, d + 16'h0019});
    wr(8'h00, 32'h1);
    ms(1'b1, d + 16'h0010);
    rd(8'h48, 33'h1);
    wr(8'h00, 32'h3);
    ms(1'b1, d + 16'h0010);
    rd(8'h48, 33'h0);
    ms(1'b1, d + 16'h0040);
    rd(8'h48, 33'h1);
    wr(8'h00, 32'h0);
    wr(8'h14, 32'h3);
    wr(8'h18, 32'h3);
    ms(1'b1, d + 16'h0040);
    rd(8'h48, 33'h1);
    repeat (80) @(posedge clk_sys);
    rd(8'h48, 33'h0);
    ms(1'b1, d);
    rd(8'h48, 33'h2);
    repeat (80) @(posedge clk_sys);
    rd(8'h48, 33'h3);
    wr(8'h14, 32'h0);
    wr(8'h18, 32'h0);
    for (i = 0; i < 3; i++) begin
      wr(8'h00, i << 3);
      ms(1'b1, i == 1 ? d + 16'h0040 : d);
      ms(1'b0, 16'h0000);
      rd(8'h48, i == 0 ? 33'h30 : 33'h31);
    end
    lrn(5'h14);
    rd(8'h1C, 33'hC8);
    rd(8'h3C, 33'hC8);
    wr(8'h00, 32'h0);
    wr(8'h1C, 32'h2);
    ms(1'b1, d);
    ms(1'b0, 16'h0000);
    rd(8'h48, 33'h3);
    repeat (80) @(posedge clk_sys);
    rd(8'h48, 33'h12);
    lrn(5'h15);
    rd(8'h3C, 33'h0);
    wr(8'h40, 32'h1);
    wr(8'h00, 32'h20);
    wr(8'h20, 32'h20);
    ms(1'b1, d + 16'h0040);
    wr(8'h44, 32'h1);
    for (i = 0; i < 12; i++) begin
      syncSeen <= 1'b1;
      @(posedge clk_sys);
      syncSeen <= 1'b0;
      repeat (9) @(posedge clk_sys);
    end
    rd(8'h48, 33'h0);
    repeat (80) @(posedge clk_sys);
    rd(8'h48, 33'h43);
    wr(8'h08, 32'hFFFF);
    rd(8'h08, 33'h56A1);
    rd(8'h48, 33'h47);
    chk({31'h0, cfgWarn}, 33'h1);
    chk({31'h0, switchTwo, switchOne}, 33'h3);
    @(posedge clk_sys);
    conclude;
  end
endmodule
